/* rtl/rnf_pkg.sv */
package rnf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned RNF_DATA_W = 32;                 // Register width
  localparam int unsigned RNF_ADDR_W = 12;                 // Decoded byte address width
  localparam int unsigned RNF_NODE_W = 6;                  // Source node number width
  localparam int unsigned RNF_BUS_W  = 10;                 // Source bus number width

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] RNF_ASYNC_LOW_SET_OFS   = 12'h108; // Lower async filter, set
  localparam logic [11:0] RNF_ASYNC_LOW_CLR_OFS   = 12'h10c; // Lower async filter, clear
  localparam logic [11:0] RNF_PHYS_HIGH_SET_OFS   = 12'h110; // Upper phys filter, set
  localparam logic [11:0] RNF_PHYS_HIGH_CLR_OFS   = 12'h114; // Upper phys filter, clear
  localparam logic [11:0] RNF_ASYNC_HIGH_SET_OFS  = 12'h180; // Upper async entries, set
  localparam logic [11:0] RNF_ASYNC_HIGH_CLR_OFS  = 12'h184; // Upper async entries, clear
  localparam logic [11:0] RNF_STATUS_OFS          = 12'h188; // Request decision status

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and implemented bits
  localparam logic [31:0] RNF_FILTER_RESET        = 32'h0000_0000; // All filters closed
  localparam logic [31:0] RNF_ASYNC_LOW_IMPL      = 32'hffff_ffff; // Nodes 0 to 31
  localparam logic [31:0] RNF_ASYNC_HIGH_IMPL     = 32'h0000_000f; // Nodes 32 to 35
  localparam logic [31:0] RNF_PHYS_HIGH_IMPL      = 32'hfff8_0000; // Bit 31, nodes 51 to 62
  localparam logic [31:0] RNF_NO_KEEP             = 32'h0000_0000; // Nothing survives
  localparam logic [31:0] RNF_PHYS_HIGH_KEEP      = 32'h8000_0000; // Remote bus bit survives

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and node ranges
  localparam int unsigned  RNF_REMOTE_BUS_BIT     = 31;            // Remote bus accept bit
  localparam logic [5:0]   RNF_HIGH_NODE_BASE     = 6'h20;         // Node of high bit 0
  localparam logic [5:0]   RNF_ASYNC_HIGH_LAST    = 6'h23;         // Highest async high node
  localparam logic [5:0]   RNF_PHYS_HIGH_FIRST    = 6'h33;         // Lowest phys high node
  localparam logic [5:0]   RNF_PHYS_HIGH_LAST     = 6'h3e;         // Highest phys high node
  localparam logic [9:0]   RNF_LOCAL_BUS_ALIAS    = 10'h3ff;       // Bus number meaning local

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int unsigned RNF_ST_ACK_BIT          = 0;             // Last request acked
  localparam int unsigned RNF_ST_PHYS_BIT         = 1;             // Last went to phys
  localparam int unsigned RNF_ST_ASYNC_BIT        = 2;             // Last went to async
  localparam int unsigned RNF_ST_LOCAL_BIT        = 3;             // Last came from local bus
  localparam int unsigned RNF_ST_NODE_LSB         = 8;             // Last source node

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings
  localparam logic [1:0] RNF_HTRANS_NONSEQ        = 2'h2;          // Non-sequential
  localparam logic [2:0] RNF_HSIZE_WORD           = 3'h2;          // 32-bit transfer
  localparam logic       RNF_HRESP_OKAY           = 1'h0;          // Okay response

endpackage

/* rtl/rnf_setclr_reg.sv */
// One set/clear filter register: software writes ones to set or clear
// bits, the link reset clears all but the kept bits.
module rnf_setclr_reg
  import rnf_pkg::*;
#(
  parameter int unsigned W         = 32,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] IMPL_MASK = 32'hffff_ffff,
  parameter logic [31:0] KEEP_MASK = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Software access
  input  wire logic         set_we,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] wdata,
  // Link reset pulse
  input  wire logic         link_clr,
  // Register value and value after this cycle
  output logic      [W-1:0] q,
  output logic      [W-1:0] q_next
);

  // Width check
  if (W < 1 || W > 32) begin : g_bad_width
    $error("rnf_setclr_reg: W must lie in 1 to 32");
  end

  logic [W-1:0] value_reg;    // Stored filter bits
  logic [W-1:0] impl;         // Bits that exist
  logic [W-1:0] keep;         // Bits untouched by link reset

  assign impl = IMPL_MASK[W-1:0];
  assign keep = KEEP_MASK[W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next value: link reset, then set, then clear
  always_comb begin
    q_next = value_reg;
    if (link_clr) begin
      q_next = value_reg & keep;
    end
    if (set_we) begin
      q_next = q_next | (wdata & impl);
    end
    if (clr_we) begin
      q_next = q_next & ~wdata;
    end
  end

  // Storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= RESET_VAL[W-1:0];
    end else begin
      value_reg <= q_next;
    end
  end

  assign q = value_reg;

endmodule // rnf_setclr_reg

/* rtl/rnf_request_filters.sv */
// How it works
// - Lower async filter, nodes 0-31, set/clear
// - Lower async filter screens like upper one
// - Lower async bit n accepts node n
// - Upper async bits 3-0 accept nodes 35-32
// - Upper physical filter, set/clear addresses
// - Physical requests checked async, then physical
// - Physical bit clear routes to async context
// - Node comparison only for local bus
// - Remote bus requests need bit 31 set
// - Bit 31 survives the link reset event
// - Physical bits 30-19 route nodes 62-51 (never here: those nodes have no async bit)
// - Async bit clear: no ack, no queue
//
// Added by the designer: register access over AHB-Lite.
module rnf_request_filters
  import rnf_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [RNF_ADDR_W-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [RNF_DATA_W-1:0] hwdata,
  input  wire logic                  hready,
  output logic      [RNF_DATA_W-1:0] hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Link side
  input  wire logic                  link_reset_event,
  input  wire logic [RNF_BUS_W-1:0]  local_bus_id,
  // Incoming request
  input  wire logic                  req_valid,
  input  wire logic [RNF_BUS_W-1:0]  req_src_bus,
  input  wire logic [RNF_NODE_W-1:0] req_src_node,
  input  wire logic                  req_phys,
  // Decision
  output logic                       dec_valid,
  output logic                       dec_ack,
  output logic                       dec_to_phys,
  output logic                       dec_to_async
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus data phase state
  logic                  dp_write_reg;   // Write data phase pending
  logic [RNF_ADDR_W-1:0] dp_addr_reg;    // Address of pending write
  logic [RNF_DATA_W-1:0] hrdata_reg;     // Read data
  logic                  hreadyout_reg;  // Ready out
  logic                  hresp_reg;      // Response out
  logic                  addr_phase;     // Valid address phase this cycle

  // Filter registers
  logic [31:0]           async_low;      // Lower async filter
  logic [31:0]           async_high;     // Upper async entries
  logic [31:0]           phys_high;      // Upper physical filter
  logic [31:0]           async_low_nx;   // Values after this cycle
  logic [31:0]           async_high_nx;
  logic [31:0]           phys_high_nx;

  // Write strobes
  logic                  we_al_set;
  logic                  we_al_clr;
  logic                  we_ah_set;
  logic                  we_ah_clr;
  logic                  we_ph_set;
  logic                  we_ph_clr;

  // Decision terms
  logic                  src_local;      // Source sits on our bus
  logic                  async_hit;      // Async filter bit for the node
  logic                  phys_hit;       // Physical filter bit for the node
  logic                  accept;         // Request acknowledged and queued
  logic                  to_phys;        // Routed to physical context

  // Decision outputs and status
  logic                  dec_valid_reg;
  logic                  dec_ack_reg;
  logic                  dec_to_phys_reg;
  logic                  dec_to_async_reg;
  logic [31:0]           status_reg;     // Last decision, readable
  logic [31:0]           status_next;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase qualification: only whole-word transfers are decoded
  // SEQ is taken like NONSEQ; IDLE and BUSY are not decoded
  // Narrow transfers are ignored: reads keep the old data, writes are lost
  assign addr_phase = hsel && hready && (htrans == RNF_HTRANS_NONSEQ || htrans[1])
                      && (hsize == RNF_HSIZE_WORD);

  // Capture write address phase for the data phase
  // The address is held while hready is low, so a stalled data phase still
  // writes the register that its own address phase named
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end else if (hready) begin
      dp_write_reg <= addr_phase && hwrite;
      dp_addr_reg  <= haddr;
    end
  end

  // Write strobes in the data phase
  // The upper async entries only hold nodes 32 to 35; other bits read 0
  assign we_al_set = dp_write_reg && (dp_addr_reg == RNF_ASYNC_LOW_SET_OFS);
  assign we_al_clr = dp_write_reg && (dp_addr_reg == RNF_ASYNC_LOW_CLR_OFS);
  assign we_ah_set = dp_write_reg && (dp_addr_reg == RNF_ASYNC_HIGH_SET_OFS);
  assign we_ah_clr = dp_write_reg && (dp_addr_reg == RNF_ASYNC_HIGH_CLR_OFS);
  assign we_ph_set = dp_write_reg && (dp_addr_reg == RNF_PHYS_HIGH_SET_OFS);
  assign we_ph_clr = dp_write_reg && (dp_addr_reg == RNF_PHYS_HIGH_CLR_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Lower async filter, one bit per node 0 to 31
  // Each register has its own set and clear strobes; one write per cycle
  // means the set and clear of one register never meet
  rnf_setclr_reg #(
    .W         (32),
    .RESET_VAL (RNF_FILTER_RESET),
    .IMPL_MASK (RNF_ASYNC_LOW_IMPL),
    .KEEP_MASK (RNF_NO_KEEP)
  ) u_async_low (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_we   (we_al_set),
    .clr_we   (we_al_clr),
    .wdata    (hwdata),
    .link_clr (link_reset_event),
    .q        (async_low),
    .q_next   (async_low_nx)
  );

  // Upper async entries for nodes 32 to 35
  rnf_setclr_reg #(
    .W         (32),
    .RESET_VAL (RNF_FILTER_RESET),
    .IMPL_MASK (RNF_ASYNC_HIGH_IMPL),
    .KEEP_MASK (RNF_NO_KEEP)
  ) u_async_high (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_we   (we_ah_set),
    .clr_we   (we_ah_clr),
    .wdata    (hwdata),
    .link_clr (link_reset_event),
    .q        (async_high),
    .q_next   (async_high_nx)
  );

  // Upper physical filter: remote bus bit keeps its value on link reset
  rnf_setclr_reg #(
    .W         (32),
    .RESET_VAL (RNF_FILTER_RESET),
    .IMPL_MASK (RNF_PHYS_HIGH_IMPL),
    .KEEP_MASK (RNF_PHYS_HIGH_KEEP)
  ) u_phys_high (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_we   (we_ph_set),
    .clr_we   (we_ph_clr),
    .wdata    (hwdata),
    .link_clr (link_reset_event),
    .q        (phys_high),
    .q_next   (phys_high_nx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data, taken at the address phase from the values that will hold
  // after any write still in its data phase, so a read right after a write
  // sees the new contents
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (addr_phase && !hwrite) begin
      case (haddr)
        RNF_ASYNC_LOW_SET_OFS,
        RNF_ASYNC_LOW_CLR_OFS:  hrdata_reg <= async_low_nx;
        RNF_ASYNC_HIGH_SET_OFS,
        RNF_ASYNC_HIGH_CLR_OFS: hrdata_reg <= async_high_nx;
        RNF_PHYS_HIGH_SET_OFS,
        RNF_PHYS_HIGH_CLR_OFS:  hrdata_reg <= phys_high_nx;
        RNF_STATUS_OFS:         hrdata_reg <= status_reg;
        // Unmapped addresses read zero
        // Writes to them are dropped, still with an okay response
        default:                hrdata_reg <= '0;
      endcase
    end
  end

  // Zero wait states: ready from the first edge after reset
  // No access ever stalls, so a data phase always ends one edge later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
    end
  end

  // Response: this slave never refuses a transfer, so the register only
  // ever holds okay; it keeps the output on a flop like the others
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= RNF_HRESP_OKAY;
    end else begin
      hresp_reg <= RNF_HRESP_OKAY;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Source on the local bus: own bus number or the local alias
  assign src_local = (req_src_bus == RNF_LOCAL_BUS_ALIAS)
                     || (req_src_bus == local_bus_id);

  // Async filter lookup: low register holds nodes 0-31, high nodes 32-35
  // Nodes 36 to 63 have no async entry and are always refused from the local bus, which also
  // keeps local physical requests from nodes 51 to 62 from passing
  always_comb begin
    async_hit = 1'b0;
    if (!req_src_node[5]) begin
      async_hit = async_low[req_src_node[4:0]];
    end else if (req_src_node <= RNF_ASYNC_HIGH_LAST) begin
      async_hit = async_high[req_src_node[4:0]];
    end
  end

  // Physical filter lookup: bit k of the high register is node 32 plus k
  // Nodes below 51 have no physical entry here and fall back to async
  always_comb begin
    phys_hit = 1'b0;
    if (req_src_node >= RNF_PHYS_HIGH_FIRST && req_src_node <= RNF_PHYS_HIGH_LAST) begin
      phys_hit = phys_high[req_src_node[4:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and routing
  // Remote sources skip the per-node lookup; the remote bus bit alone
  // decides whether they are acknowledged
  always_comb begin
    if (src_local) begin
      // Local source: async filter gates the ack and the queueing
      accept  = async_hit;
      // Physical target must pass async first, then the physical filter
      to_phys = req_phys && async_hit && phys_hit;
    end else begin
      // Remote source: all or nothing by the remote bus bit
      accept  = phys_high[RNF_REMOTE_BUS_BIT];
      to_phys = req_phys && phys_high[RNF_REMOTE_BUS_BIT];
    end
  end

  // Registered decision, one cycle after the request
  // Filter values are those before any write of the same cycle, so a
  // request never sees half of a register update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_valid_reg    <= 1'b0;
      dec_ack_reg      <= 1'b0;
      dec_to_phys_reg  <= 1'b0;
      dec_to_async_reg <= 1'b0;
    end else begin
      dec_valid_reg    <= req_valid;
      dec_ack_reg      <= req_valid && accept;
      dec_to_phys_reg  <= req_valid && to_phys;
      // Accepted but not physical: goes to the async request receive context
      dec_to_async_reg <= req_valid && accept && !to_phys;
    end
  end

  // Decision outputs come straight from their flops
  assign dec_valid    = dec_valid_reg;
  assign dec_ack      = dec_ack_reg;
  assign dec_to_phys  = dec_to_phys_reg;
  assign dec_to_async = dec_to_async_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status: last decision, for software to inspect
  // It changes only when a request arrives, so software reads the last
  // decision however long ago it was made
  always_comb begin
    status_next                               = '0;
    status_next[RNF_ST_ACK_BIT]               = accept;
    status_next[RNF_ST_PHYS_BIT]              = to_phys;
    status_next[RNF_ST_ASYNC_BIT]             = accept && !to_phys;
    status_next[RNF_ST_LOCAL_BIT]             = src_local;
    status_next[RNF_ST_NODE_LSB +: RNF_NODE_W] = req_src_node;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else if (req_valid) begin
      status_reg <= status_next;
    end
  end

endmodule // rnf_request_filters

/* tb/rnf_monitor.sv */
// Watches the decision outputs against the request inputs
module rnf_monitor
  import rnf_pkg::*;
(
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Bus side
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic                  hresp,
  // Request side
  input wire logic [RNF_BUS_W-1:0]  local_bus_id,
  input wire logic                  req_valid,
  input wire logic [RNF_BUS_W-1:0]  req_src_bus,
  input wire logic [RNF_NODE_W-1:0] req_src_node,
  input wire logic                  req_phys,
  // Decision side
  input wire logic                  dec_valid,
  input wire logic                  dec_ack,
  input wire logic                  dec_to_phys,
  input wire logic                  dec_to_async
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req_local; // Source sits on our own bus
  assign req_local = (req_src_bus == RNF_LOCAL_BUS_ALIAS) || (req_src_bus == local_bus_id);
  ////////////////////////////////////////
  dec_follows_a: assert property (req_valid |=> dec_valid)
    else $error("decision missing after request");
  dec_quiet_a: assert property (!req_valid |=> !(dec_valid || dec_ack || dec_to_phys))
    else $error("decision without request");
  async_split_a: assert property (dec_valid |-> dec_to_async == (dec_ack && !dec_to_phys))
    else $error("async routing wrong");
  phys_after_a: assert property (dec_to_phys |-> dec_ack && dec_valid)
    else $error("physical route without acceptance");
  high_async_a: assert property (req_valid && req_local && req_src_node > RNF_ASYNC_HIGH_LAST
    |=> !dec_ack)
    else $error("unfiltered high node accepted");
  phys_range_a: assert property (req_valid && req_local && (req_src_node < RNF_PHYS_HIGH_FIRST
    || req_src_node > RNF_PHYS_HIGH_LAST) |=> !dec_to_phys)
    else $error("node outside physical range routed");
  aimed_async_a: assert property (req_valid && !req_phys |=> !dec_to_phys)
    else $error("async request routed physical");
  remote_aim_a: assert property (req_valid && !req_local && req_phys
    |=> dec_to_phys == dec_ack)
    else $error("remote physical request misrouted");
  resp_okay_a: assert property (hresp == RNF_HRESP_OKAY)
    else $error("bus response not okay");
  // Main scenarios reached
  cover property (dec_to_phys);
  cover property (dec_ack && dec_to_async);
  cover property (hsel && hready && htrans == RNF_HTRANS_NONSEQ && hwrite);
endmodule // rnf_monitor

bind rnf_request_filters rnf_monitor rnf_monitor_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hresp, .local_bus_id, .req_valid, .req_src_bus, .req_src_node, .req_phys,
  .dec_valid, .dec_ack, .dec_to_phys, .dec_to_async);

/* tb/rnf_node_model.sv */
// Another bus node that sends request packets to the filters
module rnf_node_model
  import rnf_pkg::*;
(
  // Clock
  input  wire logic                  hclk,
  // Request toward the filters
  output logic                       req_valid,
  output logic      [RNF_BUS_W-1:0]  req_src_bus,
  output logic      [RNF_NODE_W-1:0] req_src_node,
  output logic                       req_phys
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    req_valid = 1'b0;
    req_src_bus = 10'h000;
    req_src_node = 6'h00;
    req_phys = 1'b0;
  end
  // One request after an optional idle gap; fields scrambled once it is gone
  task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic aim,
                      input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_src_bus <= bus;
    req_src_node <= node;
    req_phys <= aim;
    @(posedge hclk);
    req_valid <= 1'b0;
    req_src_bus <= ~bus;
    req_src_node <= ~node;
    req_phys <= ~aim;
  endtask
endmodule // rnf_node_model

/* tb/testbench.sv */
// Register and request-path bench for the node filters
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rnf_pkg::*;
  localparam logic [31:0] LOW_PAT = 32'ha5a5_5a58; // Lower async pattern in use
  logic                  hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [RNF_ADDR_W-1:0] haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata, rd;
  logic                  link_reset_event, req_valid, req_phys;
  logic [9:0]            local_bus_id, req_src_bus;
  logic [5:0]            req_src_node;
  logic                  dec_valid, dec_ack, dec_to_phys, dec_to_async;
  int                    bad_count, total_checks;
  assign hready = hreadyout; // Single slave drives the bus ready
  rnf_request_filters rnf_request_filters_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .link_reset_event,
    .local_bus_id, .req_valid, .req_src_bus, .req_src_node, .req_phys, .dec_valid, .dec_ack,
    .dec_to_phys, .dec_to_async);
  rnf_node_model rnf_node_model_inst (.hclk, .req_valid, .req_src_bus, .req_src_node,
    .req_phys);
  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  ////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite word transfer, waiting on ready in both phases
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= RNF_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= RNF_HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    xfer(1'b1, addr, wd);
  endtask
  task automatic rchk(input logic [11:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0000_0000);
    check(rd, exp);
  endtask
  // Send a request, then compare {valid, ack, phys, async} once settled
  task automatic req(input logic [9:0] bus, input logic [5:0] node, input logic aim,
                     input logic [2:0] exp);
    rnf_node_model_inst.send(bus, node, aim, 0);
    @(negedge hclk);
    check({28'h000_0000, dec_valid, dec_ack, dec_to_phys, dec_to_async},
          {28'h000_0000, 1'b1, exp});
  endtask
  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, link_reset_event} = 4'h0;
    {haddr, htrans, hsize, hwdata} = '0;
    local_bus_id = 10'h012;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge hclk);
    check({31'h0000_0000, hreadyout}, 32'h0000_0000);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check({31'h0000_0000, hreadyout}, 32'h0000_0001);
    check({31'h0000_0000, hresp}, {31'h0000_0000, RNF_HRESP_OKAY});
    // Reset values of the four lower async and upper physical addresses
    for (int i = 0; i < 4; i++) rchk(RNF_ASYNC_LOW_SET_OFS + 12'(4 * i), 32'h0000_0000);
    // Set and clear by ones
    wr(RNF_ASYNC_LOW_SET_OFS, 32'ha5a5_5a5a);
    wr(RNF_ASYNC_LOW_SET_OFS, 32'h0000_0001);
    rchk(RNF_ASYNC_LOW_CLR_OFS, 32'ha5a5_5a5b);
    wr(RNF_ASYNC_LOW_CLR_OFS, 32'h0000_0003);
    rchk(RNF_ASYNC_LOW_SET_OFS, LOW_PAT);
    // Every lower node against its own bit
    for (int n = 0; n < 32; n++) req(10'h3ff, 6'(n), 1'b0, {LOW_PAT[n], 1'b0, LOW_PAT[n]});
    req(10'h012, 6'd3, 1'b0, 3'b101);
    // Upper async entries, node 36 stays closed
    wr(RNF_ASYNC_HIGH_SET_OFS, 32'h0000_0005);
    for (int n = 32; n < 37; n++) req(10'h3ff, 6'(n), 1'b0, (n == 32 || n == 34) ? 3'b101 : 3'b000);
    // Remote bus refused while bit 31 is clear
    req(10'h001, 6'd3, 1'b1, 3'b000);
    wr(RNF_PHYS_HIGH_SET_OFS, 32'h7fff_ffff);
    rchk(RNF_PHYS_HIGH_CLR_OFS, 32'h7ff8_0000);
    req(10'h3ff, 6'd51, 1'b1, 3'b000);
    req(10'h3ff, 6'd3, 1'b1, 3'b101);
    rchk(RNF_STATUS_OFS, 32'h0000_030d);
    // Remote bus admitted once bit 31 is set
    wr(RNF_PHYS_HIGH_SET_OFS, 32'h8000_0000);
    req(10'h001, 6'd0, 1'b1, 3'b110);
    req(10'h001, 6'd0, 1'b0, 3'b101);
    rchk(RNF_STATUS_OFS, 32'h0000_0005);
    // Link reset keeps only the remote bus bit
    @(posedge hclk);
    link_reset_event <= 1'b1;
    @(posedge hclk);
    link_reset_event <= 1'b0;
    rchk(RNF_PHYS_HIGH_SET_OFS, 32'h8000_0000);
    rchk(RNF_ASYNC_LOW_SET_OFS, 32'h0000_0000);
    // Unmapped read, then clearing the kept bit
    rchk(12'h200, 32'h0000_0000);
    wr(RNF_PHYS_HIGH_CLR_OFS, 32'h8000_0000);
    rchk(RNF_PHYS_HIGH_SET_OFS, 32'h0000_0000);
    print_verdict();
  end
endmodule // testbench
